/* core/guest_trap_deleg.sv */
// guest trap delegation masks, injected interrupts and host interrupt selection
`include "guest_trap_defines.svh"

module guest_trap_deleg #(
    parameter int NATIVE_REG_WIDTH = 32,
    parameter int INSN_ALIGN_WIDTH = 32,
    parameter int GEILEN           = 8,
    parameter logic [31:0] EXC_UPPER_WR_MASK = 32'h00000000
) (
    input  wire logic                         clk_in,
    input  wire logic                         rst_b_in,
    // axi4-lite slave
    input  wire logic [7:0]                   awaddr_in,
    input  wire logic                         awvalid_in,
    output logic                              awready_out,
    input  wire logic [31:0]                  wdata_in,
    input  wire logic [3:0]                   wstrb_in,
    input  wire logic                         wvalid_in,
    output logic                              wready_out,
    output logic [1:0]                        bresp_out,
    output logic                              bvalid_out,
    input  wire logic                         bready_in,
    input  wire logic [7:0]                   araddr_in,
    input  wire logic                         arvalid_in,
    output logic                              arready_out,
    output logic [31:0]                       rdata_out,
    output logic [1:0]                        rresp_out,
    output logic                              rvalid_out,
    input  wire logic                         rready_in,
    // hart trap logic
    input  wire guest_trap_pkg::hart_state_type hart_state_in,
    input  wire guest_trap_pkg::exc_req_type  exc_req_in,
    input  wire logic [15:0]                  sup_int_pending_in,
    input  wire logic [15:0]                  sup_int_enable_in,
    input  wire logic [15:0]                  machine_interrupt_delegate_in,
    // platform interrupt sources
    input  wire logic [63:0]                  guest_ext_line_pending_in,
    input  wire logic [63:0]                  guest_ext_line_enable_in,
    input  wire logic [5:0]                   guest_ext_line_select_in,
    input  wire logic                         plat_guest_ext_irq_in,
    input  wire logic                         plat_guest_timer_irq_in,
    // decisions back to the hart
    output logic                              exc_to_guest_out,
    output guest_trap_pkg::irq_sel_type       host_irq_out,
    output guest_trap_pkg::irq_sel_type       guest_irq_out,
    output logic [15:0]                       hyp_int_pending_out
);
    import guest_trap_pkg::*;

    // guest external lines GEILEN:1 exist, bit 0 never does
    localparam logic [63:0] LINE_MASK = ((64'h1 << (GEILEN + 1)) - 64'h1) & ~64'h1;
    localparam logic        UPPER_EXISTS = (NATIVE_REG_WIDTH == 32);
    localparam logic [31:0] EXC_LOW_MASK = `EXC_DELEG_WR_MASK
                                         | ((INSN_ALIGN_WIDTH == 32) ? `EXC_DELEG_BIT0 : 32'h00000000);
    // supervisor-writable positions never appear in the hypervisor pair
    localparam logic [31:0] HYP_VIEW_MASK = ~`SUP_ENABLE_WR_MASK;

    // register storage
    logic [31:0] exc_deleg_lo;
    logic [31:0] exc_deleg_hi;
    logic [31:0] int_deleg;
    logic [31:0] injected;
    logic [31:0] hyp_enable;

    // bus handshake state
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic        next_w_held;
    logic        next_bvalid;
    logic        next_rvalid;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        do_write;

    // interrupt views
    logic        summary_pending;
    logic        selected_line;
    logic        guest_ext_pend;
    logic        guest_timer_pend;
    logic [31:0] hyp_pending;
    logic [15:0] host_candidates;
    logic [15:0] guest_candidates;
    logic        host_mode_ok;
    irq_sel_type next_host_irq;
    irq_sel_type next_guest_irq;
    logic        next_exc_to_guest;

    // byte-merge a write, keeping writable bits
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    // interrupt views

    // summary of enabled guest external lines
    assign summary_pending = |(guest_ext_line_pending_in & guest_ext_line_enable_in & LINE_MASK);

    // selected line ignores line enable; select zero picks nothing
    always_comb begin
        selected_line = 1'b0;
        if (guest_ext_line_select_in != 6'h00) begin
            selected_line = guest_ext_line_pending_in[guest_ext_line_select_in]
                          & LINE_MASK[guest_ext_line_select_in];
        end
    end

    assign guest_ext_pend   = injected[`BIT_GUEST_EXT] | selected_line | plat_guest_ext_irq_in;
    assign guest_timer_pend = injected[`BIT_GUEST_TIMER] | plat_guest_timer_irq_in;

    // pending view, all bits read-only except the software alias
    always_comb begin
        hyp_pending = 32'h00000000;
        hyp_pending[`BIT_SUMMARY]     = summary_pending;
        hyp_pending[`BIT_GUEST_EXT]   = guest_ext_pend;
        hyp_pending[`BIT_GUEST_TIMER] = guest_timer_pend;
        hyp_pending[`BIT_GUEST_SOFT]  = injected[`BIT_GUEST_SOFT];
        hyp_pending = hyp_pending & HYP_VIEW_MASK;
    end

    // host eligible from lower modes, or host supervisor with global enable
    always_comb begin
        host_mode_ok = 1'b0;
        if (hart_state_in.guest_mode_on || hart_state_in.mode == PRIV_USER) begin
            host_mode_ok = 1'b1;
        end else if (hart_state_in.mode == PRIV_SUP) begin
            host_mode_ok = hart_state_in.sup_global_int_enable;
        end
    end

    // candidates: pending and enabled, host side not guest-delegated
    assign host_candidates = ((sup_int_pending_in & sup_int_enable_in)
                           | (hyp_pending[15:0] & hyp_enable[15:0]))
                           & ~int_deleg[15:0]
                           & {16{host_mode_ok}};
    assign guest_candidates = hyp_pending[15:0] & hyp_enable[15:0]
                            & int_deleg[15:0] & machine_interrupt_delegate_in;

    // fixed priority toward host supervisor
    always_comb begin
        next_host_irq = '0;
        if (host_candidates[`BIT_SUP_EXT]) begin
            next_host_irq = '{valid: 1'b1, cause: `CAUSE_SUP_EXT};
        end else if (host_candidates[`BIT_SUP_SOFT]) begin
            next_host_irq = '{valid: 1'b1, cause: `CAUSE_SUP_SOFT};
        end else if (host_candidates[`BIT_SUP_TIMER]) begin
            next_host_irq = '{valid: 1'b1, cause: `CAUSE_SUP_TIMER};
        end else if (host_candidates[`BIT_SUMMARY]) begin
            next_host_irq = '{valid: 1'b1, cause: `CAUSE_SUMMARY};
        end else if (host_candidates[`BIT_GUEST_EXT]) begin
            next_host_irq = '{valid: 1'b1, cause: `CAUSE_GUEST_EXT};
        end else if (host_candidates[`BIT_GUEST_SOFT]) begin
            next_host_irq = '{valid: 1'b1, cause: `CAUSE_GUEST_SOFT};
        end else if (host_candidates[`BIT_GUEST_TIMER]) begin
            next_host_irq = '{valid: 1'b1, cause: `CAUSE_GUEST_TIMER};
        end
    end

    // guest-delegated interrupts carry supervisor causes
    always_comb begin
        next_guest_irq = '0;
        if (guest_candidates[`BIT_GUEST_EXT]) begin
            next_guest_irq = '{valid: 1'b1, cause: `CAUSE_SUP_EXT};
        end else if (guest_candidates[`BIT_GUEST_SOFT]) begin
            next_guest_irq = '{valid: 1'b1, cause: `CAUSE_SUP_SOFT};
        end else if (guest_candidates[`BIT_GUEST_TIMER]) begin
            next_guest_irq = '{valid: 1'b1, cause: `CAUSE_SUP_TIMER};
        end
    end

    // exception routing: cause indexes the 64-bit mask
    always_comb begin
        logic [63:0] full_mask;
        full_mask = {exc_deleg_hi, exc_deleg_lo};
        next_exc_to_guest = exc_req_in.valid && exc_req_in.to_host
                         && hart_state_in.guest_mode_on
                         && full_mask[exc_req_in.cause];
    end

    // registered decisions: inputs act one cycle later
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            host_irq_out        <= '0;
            guest_irq_out       <= '0;
            exc_to_guest_out    <= 1'b0;
            hyp_int_pending_out <= 16'h0000;
        end else begin
            host_irq_out        <= next_host_irq;
            guest_irq_out       <= next_guest_irq;
            exc_to_guest_out    <= next_exc_to_guest;
            hyp_int_pending_out <= hyp_pending[15:0];
        end
    end

    // axi4-lite write side

    assign aw_take  = awvalid_in & awready_out;
    assign w_take   = wvalid_in & wready_out;
    // the write lands one cycle after both halves are held
    assign do_write = aw_held & w_held & ~bvalid_out;

    always_comb begin
        next_aw_held = do_write ? 1'b0 : (aw_held | aw_take);
        next_w_held  = do_write ? 1'b0 : (w_held | w_take);
        next_bvalid  = do_write | (bvalid_out & ~bready_in);
    end

    // address and data taken in either order, held until the write
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aw_held     <= 1'b0;
            w_held      <= 1'b0;
            aw_addr     <= 8'h00;
            w_data      <= 32'h00000000;
            w_strb      <= 4'h0;
            awready_out <= 1'b0;
            wready_out  <= 1'b0;
        end else begin
            aw_held     <= next_aw_held;
            w_held      <= next_w_held;
            awready_out <= ~next_aw_held & ~next_bvalid;
            wready_out  <= ~next_w_held & ~next_bvalid;
            if (aw_take) begin
                aw_addr <= awaddr_in;
            end
            if (w_take) begin
                w_data <= wdata_in;
                w_strb <= wstrb_in;
            end
        end
    end

    // write response; unmapped addresses get a slave error
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bvalid_out <= 1'b0;
            bresp_out  <= `RESP_OKAY;
        end else begin
            bvalid_out <= next_bvalid;
            if (do_write) begin
                case (aw_addr)
                    `ADDR_EXC_DELEG, `ADDR_INT_DELEG, `ADDR_INJECTED,
                    `ADDR_HYP_PENDING, `ADDR_HYP_ENABLE, `ADDR_STATUS: begin
                        bresp_out <= `RESP_OKAY;
                    end
                    `ADDR_EXC_DELEG_UP: begin
                        bresp_out <= UPPER_EXISTS ? `RESP_OKAY : `RESP_SLVERR;
                    end
                    default: begin
                        bresp_out <= `RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // delegation masks, only listed bits hold storage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            exc_deleg_lo <= `REG_RESET;
            exc_deleg_hi <= `REG_RESET;
            int_deleg    <= `REG_RESET;
        end else if (do_write) begin
            if (aw_addr == `ADDR_EXC_DELEG) begin
                exc_deleg_lo <= merge(exc_deleg_lo, w_data, w_strb, EXC_LOW_MASK);
            end
            if (aw_addr == `ADDR_EXC_DELEG_UP && UPPER_EXISTS) begin
                exc_deleg_hi <= merge(exc_deleg_hi, w_data, w_strb, EXC_UPPER_WR_MASK);
            end
            if (aw_addr == `ADDR_INT_DELEG) begin
                int_deleg <= merge(int_deleg, w_data, w_strb, `INT_DELEG_WR_MASK);
            end
        end
    end

    // injected bits; software bit shared with pending view
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            injected <= `REG_RESET;
        end else if (do_write) begin
            if (aw_addr == `ADDR_INJECTED) begin
                injected <= merge(injected, w_data, w_strb, `INJECTED_WR_MASK);
            end else if (aw_addr == `ADDR_HYP_PENDING && w_strb[0]) begin
                injected[`BIT_GUEST_SOFT] <= w_data[`BIT_GUEST_SOFT];
            end
        end
    end

    // enables exist only where an interrupt can become pending
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hyp_enable <= `REG_RESET;
        end else if (do_write && aw_addr == `ADDR_HYP_ENABLE) begin
            hyp_enable <= merge(hyp_enable, w_data, w_strb, `HYP_ENABLE_WR_MASK & HYP_VIEW_MASK);
        end
    end

    // axi4-lite read side

    assign ar_take     = arvalid_in & arready_out;
    assign next_rvalid = ar_take | (rvalid_out & ~rready_in);

    // read data captured at address take, held until accepted
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rvalid_out  <= 1'b0;
            arready_out <= 1'b0;
            rdata_out   <= 32'h00000000;
            rresp_out   <= `RESP_OKAY;
        end else begin
            rvalid_out  <= next_rvalid;
            arready_out <= ~next_rvalid;
            if (ar_take) begin
                rresp_out <= `RESP_OKAY;
                case (araddr_in)
                    `ADDR_EXC_DELEG: begin
                        rdata_out <= exc_deleg_lo;
                    end
                    `ADDR_EXC_DELEG_UP: begin
                        rdata_out <= UPPER_EXISTS ? exc_deleg_hi : 32'h00000000;
                        rresp_out <= UPPER_EXISTS ? `RESP_OKAY : `RESP_SLVERR;
                    end
                    `ADDR_INT_DELEG: begin
                        rdata_out <= int_deleg;
                    end
                    `ADDR_INJECTED: begin
                        rdata_out <= injected;
                    end
                    `ADDR_HYP_PENDING: begin
                        rdata_out <= hyp_pending;
                    end
                    `ADDR_HYP_ENABLE: begin
                        rdata_out <= hyp_enable;
                    end
                    `ADDR_STATUS: begin
                        // live decision state for software
                        rdata_out <= {16'h0000, next_guest_irq.valid, 1'b0, next_guest_irq.cause,
                                      next_host_irq.valid, 1'b0, next_host_irq.cause};
                    end
                    default: begin
                        rdata_out <= 32'h00000000;
                        rresp_out <= `RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule

/* core/guest_trap_defines.svh */
// constants for the guest trap delegation and interrupt block
`ifndef GUEST_TRAP_DEFINES_SVH
`define GUEST_TRAP_DEFINES_SVH

// register byte addresses
`define ADDR_EXC_DELEG      8'h00
`define ADDR_EXC_DELEG_UP   8'h04
`define ADDR_INT_DELEG      8'h08
`define ADDR_INJECTED       8'h0C
`define ADDR_HYP_PENDING    8'h10
`define ADDR_HYP_ENABLE     8'h14
`define ADDR_STATUS         8'h18

// writable masks
`define EXC_DELEG_WR_MASK   32'h000CB1FE
`define EXC_DELEG_BIT0      32'h00000001
`define INT_DELEG_WR_MASK   32'h00000444
`define INJECTED_WR_MASK    32'h00000444
`define HYP_ENABLE_WR_MASK  32'h00001444
`define SUP_ENABLE_WR_MASK  32'h00000222

// interrupt bit positions
`define BIT_SUP_SOFT        1
`define BIT_GUEST_SOFT      2
`define BIT_SUP_TIMER       5
`define BIT_GUEST_TIMER     6
`define BIT_SUP_EXT         9
`define BIT_GUEST_EXT       10
`define BIT_SUMMARY         12

// cause codes
`define CAUSE_SUP_SOFT      6'h01
`define CAUSE_GUEST_SOFT    6'h02
`define CAUSE_SUP_TIMER     6'h05
`define CAUSE_GUEST_TIMER   6'h06
`define CAUSE_SUP_EXT       6'h09
`define CAUSE_GUEST_EXT     6'h0A
`define CAUSE_SUMMARY       6'h0C

// reset values and bus answers
`define REG_RESET           32'h00000000
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* core/guest_trap_pkg.sv */
// types for the guest trap delegation and interrupt block
package guest_trap_pkg;

    // privilege of the hart at the time of the decision
    typedef enum logic [1:0] {
        PRIV_USER  = 2'h0,
        PRIV_SUP   = 2'h1,
        PRIV_RSVD  = 2'h2,
        PRIV_MACH  = 2'h3
    } priv_mode_type;

    // a selected interrupt: valid flag and cause code
    typedef struct packed {
        logic       valid;
        logic [5:0] cause;
    } irq_sel_type;

    // synchronous exception offered by the hart
    typedef struct packed {
        logic       valid;
        logic       to_host;
        logic [5:0] cause;
    } exc_req_type;

    // hart state that gates host interrupts
    typedef struct packed {
        logic          guest_mode_on;
        priv_mode_type mode;
        logic          sup_global_int_enable;
    } hart_state_type;

endpackage

/* verification/guest_trap_monitor.sv */
// port assertions for guest trap delegation
`include "guest_trap_defines.svh"
module guest_trap_monitor #(
    parameter int GEILEN = 8
) (
    input wire logic                           clk_in,
    input wire logic                           rst_b_in,
    input wire guest_trap_pkg::hart_state_type hart_state_in,
    input wire guest_trap_pkg::exc_req_type    exc_req_in,
    input wire logic [15:0]                    sup_int_pending_in,
    input wire logic [15:0]                    sup_int_enable_in,
    input wire logic [63:0]                    guest_ext_line_pending_in,
    input wire logic [63:0]                    guest_ext_line_enable_in,
    input wire logic                           plat_guest_ext_irq_in,
    input wire logic                           plat_guest_timer_irq_in,
    input wire logic                           exc_to_guest_out,
    input wire guest_trap_pkg::irq_sel_type    host_irq_out,
    input wire guest_trap_pkg::irq_sel_type    guest_irq_out,
    input wire logic [15:0]                    hyp_int_pending_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import guest_trap_pkg::*;
    logic elig;
    // host permission; from machine mode only while guest_mode_on is set
    assign elig = hart_state_in.guest_mode_on || hart_state_in.mode == PRIV_USER ||
        (hart_state_in.mode == PRIV_SUP && hart_state_in.sup_global_int_enable);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // decisions lag one register stage
    chk_exc_no_guest: assert property (!(exc_req_in.valid && exc_req_in.to_host &&
        hart_state_in.guest_mode_on) |=> !exc_to_guest_out) else $error("exception sent to guest");
    chk_summary_view: assert property (1'b1 |=> hyp_int_pending_out[12] ==
        $past(|(guest_ext_line_pending_in[GEILEN:1] & guest_ext_line_enable_in[GEILEN:1])))
        else $error("summary pending wrong");
    chk_ext_source: assert property (plat_guest_ext_irq_in |=> hyp_int_pending_out[10])
        else $error("external source lost");
    chk_timer_source: assert property (plat_guest_timer_irq_in ##1 1'b1 |-> hyp_int_pending_out[6])
        else $error("timer source lost");
    chk_view_layout: assert property ((hyp_int_pending_out & 16'hEBBB) == 16'h0)
        else $error("pending view bit outside layout");
    chk_host_elig: assert property (host_irq_out.valid |-> $past(elig))
        else $error("host interrupt while not permitted");
    chk_host_prio: assert property (elig && sup_int_pending_in[9] && sup_int_enable_in[9] |=>
        host_irq_out.valid && host_irq_out.cause == `CAUSE_SUP_EXT) else $error("host priority wrong");
    chk_guest_cause: assert property (guest_irq_out.valid |-> guest_irq_out.cause inside
        {`CAUSE_SUP_SOFT, `CAUSE_SUP_TIMER, `CAUSE_SUP_EXT}) else $error("guest cause untranslated");
endmodule
bind guest_trap_deleg guest_trap_monitor #(.GEILEN(GEILEN)) guest_trap_monitor_i (.*);

/* verification/hart_model.sv */
// behavioural hart trap logic and platform interrupt sources
module hart_model (
    input  wire logic                      clk_in,
    output guest_trap_pkg::hart_state_type hart_state_out,
    output guest_trap_pkg::exc_req_type    exc_req_out,
    output logic [15:0]                    sup_pend_out,
    output logic [15:0]                    sup_en_out,
    output logic [15:0]                    mdeleg_out,
    output logic [63:0]                    line_pend_out,
    output logic [63:0]                    line_en_out,
    output logic [5:0]                     line_sel_out,
    output logic                           plat_ext_out,
    output logic                           plat_timer_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import guest_trap_pkg::*;
    // quiet hart at time zero
    initial begin
        {hart_state_out, exc_req_out, sup_pend_out, sup_en_out, mdeleg_out} = '0;
        {line_pend_out, line_en_out, line_sel_out, plat_ext_out, plat_timer_out} = '0;
    end
    // levels move just after an edge
    task automatic hart(input hart_state_type hs, exc_req_type ex);
        @(posedge clk_in);
        hart_state_out <= hs;
        exc_req_out <= ex;
    endtask
    task automatic sup(input logic [15:0] p, logic [15:0] e, logic [15:0] md);
        @(posedge clk_in);
        sup_pend_out <= p;
        sup_en_out <= e;
        mdeleg_out <= md;
    endtask
    task automatic plat(input logic [63:0] lp, logic [63:0] le, logic [5:0] sel, logic pe, logic pt);
        @(posedge clk_in);
        line_pend_out <= lp;
        line_en_out <= le;
        line_sel_out <= sel;
        plat_ext_out <= pe;
        plat_timer_out <= pt;
    endtask
endmodule

/* verification/guest_trap_deleg_tb.sv */
// self-checking bench for guest trap delegation
`include "guest_trap_defines.svh"
module guest_trap_deleg_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import guest_trap_pkg::*;
    logic clk_in = 1'b0, rst_b_in = 1'b0, awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
    logic arvalid_in = 1'b0, rready_in = 1'b0, awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic [7:0] awaddr_in = 8'h0, araddr_in = 8'h0;
    logic [31:0] wdata_in = 32'h0, rdata_out, q;
    logic [1:0] bresp_out, rresp_out, r;
    hart_state_type hs;
    exc_req_type ex;
    logic [15:0] sp, se, md, hp;
    logic [63:0] lp, le;
    logic [5:0] sel;
    logic pe, pt, xg;
    irq_sel_type host, guest;
    int n_errors = 0, cmp_count = 0;
    // case tables
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
    logic [31:0] rm [5] = '{32'h000CB1FF, 32'h0, 32'h444, 32'h444, 32'h1444};
    logic [7:0] lpa [5] = '{8'h08, 8'h08, 8'h08, 8'h00, 8'h00};
    logic [7:0] lea [5] = '{8'h08, 8'h00, 8'h10, 8'h00, 8'h00};
    logic [5:0] sla [5] = '{6'h0, 6'h3, 6'h4, 6'h0, 6'h0};
    logic [15:0] hpa [5] = '{16'h1000, 16'h0400, 16'h0000, 16'h0400, 16'h0040};
    logic [15:0] spa [7] = '{16'h222, 16'h022, 16'h020, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] ina [7] = '{16'h444, 16'h444, 16'h444, 16'h444, 16'h444, 16'h044, 16'h040};
    logic [7:0] pc [7] = '{8'h49, 8'h41, 8'h45, 8'h4C, 8'h4A, 8'h42, 8'h46};
    hart_state_type hsa [4] = '{'{1'b0, PRIV_MACH, 1'b1}, '{1'b0, PRIV_SUP, 1'b0},
                                '{1'b0, PRIV_SUP, 1'b1}, '{1'b1, PRIV_SUP, 1'b0}};
    exc_req_type xea [4] = '{'{1'b1, 1'b1, 6'h02}, '{1'b1, 1'b1, 6'h09}, '{1'b1, 1'b0, 6'h02}, '{1'b1, 1'b1, 6'h02}};
    logic [4:0] pea = 5'b01000, pta = 5'b10000;
    logic [6:0] sga = 7'b0001111;
    logic [3:0] ev = 4'b1100, xgm = 4'b0111, xev = 4'b0001;

    // 20 MHz clock
    always #25 clk_in = ~clk_in;

    // strobes tied: every register is a whole word
    guest_trap_deleg guest_trap_deleg_i (.clk_in, .rst_b_in, .awaddr_in, .awvalid_in, .awready_out,
        .wdata_in, .wstrb_in(4'hF), .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in,
        .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
        .hart_state_in(hs), .exc_req_in(ex), .sup_int_pending_in(sp), .sup_int_enable_in(se),
        .machine_interrupt_delegate_in(md), .guest_ext_line_pending_in(lp), .guest_ext_line_enable_in(le),
        .guest_ext_line_select_in(sel), .plat_guest_ext_irq_in(pe), .plat_guest_timer_irq_in(pt),
        .exc_to_guest_out(xg), .host_irq_out(host), .guest_irq_out(guest), .hyp_int_pending_out(hp));
    hart_model hart_model_i (.clk_in, .hart_state_out(hs), .exc_req_out(ex), .sup_pend_out(sp),
        .sup_en_out(se), .mdeleg_out(md), .line_pend_out(lp), .line_en_out(le), .line_sel_out(sel),
        .plat_ext_out(pe), .plat_timer_out(pt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus transfer, handshakes judged before each edge
    task automatic bus(input logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        logic aw_t, w_t, ar_t, fin;
        n = 0;
        fin = 1'b0;
        @(posedge clk_in);
        awaddr_in <= a;
        araddr_in <= a;
        wdata_in <= d;
        {awvalid_in, wvalid_in, bready_in} <= {3{wr}};
        {arvalid_in, rready_in} <= {2{!wr}};
        while (!fin && n < 100) begin
            @(negedge clk_in);
            n++;
            aw_t = awvalid_in & awready_out;
            w_t = wvalid_in & wready_out;
            ar_t = arvalid_in & arready_out;
            fin = wr ? bvalid_out === 1'b1 : rvalid_out === 1'b1;
            q = rdata_out;
            r = wr ? bresp_out : rresp_out;
            @(posedge clk_in);
            if (aw_t) awvalid_in <= 1'b0;
            if (w_t) wvalid_in <= 1'b0;
            if (ar_t) arvalid_in <= 1'b0;
        end
        {bready_in, rready_in} <= 2'b00;
        if (!fin) n_errors++;
    endtask
    task automatic wr(input logic [7:0] a, logic [31:0] d, logic [1:0] er);
        bus(1'b1, a, d);
        check(32'(r), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        bus(1'b0, a, 32'h0);
        check(q, ed);
        check(32'(r), 32'(er));
    endtask
    task automatic settle();
        repeat (2) @(negedge clk_in);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the test length
    initial begin
        repeat (5000) @(posedge clk_in);
        n_errors++;
        print_verdict();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0, `RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            wr(ra[i], 32'hFFFFFFFF, `RESP_OKAY);
            rd(ra[i], rm[i], `RESP_OKAY);
        end
        wr(8'h1C, 32'hFFFFFFFF, `RESP_SLVERR);
        rd(8'h1C, 32'h0, `RESP_SLVERR);
        rd(8'h10, 32'h444, `RESP_OKAY);
        wr(8'h10, 32'h0, `RESP_OKAY);
        rd(8'h0C, 32'h440, `RESP_OKAY);
        wr(8'h0C, 32'h0, `RESP_OKAY);
        rd(8'h10, 32'h0, `RESP_OKAY);
        wr(8'h08, 32'h0, `RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            hart_model_i.plat(64'(lpa[i]), 64'(lea[i]), sla[i], pea[i], pta[i]);
            settle();
            check(32'(hp), 32'(hpa[i]));
        end
        hart_model_i.hart('{1'b0, PRIV_USER, 1'b0}, '0);
        for (int i = 0; i < 7; i++) begin
            hart_model_i.sup(spa[i], 16'h222, 16'h222);
            hart_model_i.plat(64'h2, {61'h0, sga[i], 2'b00} >> 1, 6'h0, 1'b0, 1'b0);
            wr(8'h0C, 32'(ina[i]), `RESP_OKAY);
            settle();
            check(32'(host), 32'(pc[i]));
        end
        for (int i = 0; i < 4; i++) begin
            hart_model_i.hart(hsa[i], '0);
            settle();
            check(32'(host.valid), 32'(ev[i]));
        end
        wr(8'h08, 32'h444, `RESP_OKAY);
        hart_model_i.sup(16'h0, 16'h222, 16'h666);
        for (int i = 0; i < 3; i++) begin
            wr(8'h0C, 32'(ina[i + 4]), `RESP_OKAY);
            settle();
            check(32'(guest), 32'(pc[i]));
            check(32'(host.valid), 32'h0);
        end
        hart_model_i.sup(16'h0, 16'h222, 16'h222);
        settle();
        check(32'(guest.valid), 32'h0);
        for (int i = 0; i < 4; i++) begin
            hart_model_i.hart('{xgm[i], PRIV_USER, 1'b0}, xea[i]);
            settle();
            check(32'(xg), 32'(xev[i]));
        end
        print_verdict();
    end
endmodule
